// ---- common/wrw_pkg.sv ----
// Functional notes
// - The count drops by one at every prescaler step of up to 16384 clock cycles.
// - While active, a count step from 40h to 3Fh starts a reset pulse.
// - The count runs whether or not the watchdog is active.
// - The low six count bits plus one give the timeout in prescaler steps, 1 to 64.
// - The watchdog is off after reset unless the hardware option is set, and a write can never turn it off.
// - A write with the activate bit set and the top bit clear resets now.
// - A halt while active with the halt option set gives a reset instead of entering halt.
// - A control write leaves the prescaler phase untouched.
// - Steps last 16384 clocks, some shortened by the timebase correction.
// - Timebase select picks the correction pair 4/59, 8/53, 20/35, 49/54.
// - Two option bits select an always-on watchdog and reset on halt.
// - Control holds activate in bit 7 and the count in 6:0, reset 7Fh.
// - With the hardware option the watchdog is active and bit 7 ignored.
package wrw_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_PULSE_NS = 500;
    localparam int RST_PULSE_CYCLES =
        (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [14:0] PRESC_PERIOD = 15'h4000;
    localparam int SHORT_BASE = 192;
    localparam int SHORT_MULT = 64;
    localparam logic [6:0] STEP_MAX = 7'h40;
    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    // Control fields and reset value
    localparam int CTRL_ACT_BIT = 7;
    localparam int CTRL_TOP_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h7f;
    localparam logic [6:0] EXPIRY_COUNT = 7'h40;
    // Status fields
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_HW_BIT = 2;
    localparam int ST_HALT_BIT = 3;
    localparam int ST_TB_LSB = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {SEL_CTRL, SEL_STATUS, SEL_NONE} wrw_sel_t;

    // Correction divisor per timebase
    function automatic logic [5:0] tb_msb(input logic [1:0] tb);
        unique case (tb)
            2'h0: return 6'h04;
            2'h1: return 6'h08;
            2'h2: return 6'h14;
            2'h3: return 6'h31;
        endcase
    endfunction : tb_msb

    // Correction offset per timebase
    function automatic logic [5:0] tb_lsb(input logic [1:0] tb);
        unique case (tb)
            2'h0: return 6'h3b;
            2'h1: return 6'h35;
            2'h2: return 6'h23;
            2'h3: return 6'h36;
        endcase
    endfunction : tb_lsb
endpackage : wrw_pkg

// ---- hdl/wrw_watchdog.sv ----
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module wrw_watchdog (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [1:0] timebase_select,
    input wire logic hw_watchdog_option,
    input wire logic halt_reset_option,
    input wire logic halt_exec,
    output logic halt_enter,
    output logic wdg_reset_req
);
    // Word decode shared by both bus channels
    function automatic wrw_pkg::wrw_sel_t decode(input logic [7:0] a);
        if (a[7:2] == wrw_pkg::CTRL_OFFSET[7:2]) begin
            return wrw_pkg::SEL_CTRL;
        end else if (a[7:2] == wrw_pkg::STATUS_OFFSET[7:2]) begin
            return wrw_pkg::SEL_STATUS;
        end
        return wrw_pkg::SEL_NONE;
    endfunction : decode

    // True when step n ends on a correction boundary
    function automatic logic short_step(input logic [6:0] n,
                                        input logic [5:0] m);
        logic [8:0] a;
        logic [8:0] b;
        a = {n, 2'b00};
        b = {n - 7'h01, 2'b00};
        return (a / {3'h0, m}) != (b / {3'h0, m});
    endfunction : short_step

    logic aw_held, next_aw_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [1:0] next_rresp;
    logic [31:0] next_rdata;
    logic wr_go;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic ctrl_wr;

    logic act, next_act;
    logic [6:0] count, next_count;
    logic [14:0] presc, next_presc;
    logic [6:0] step_idx, next_step_idx;
    logic [5:0] cnt_wr, next_cnt_wr;
    logic [3:0] pulse_cnt, next_pulse_cnt;
    logic next_req;
    logic opt_taken, next_opt_taken;
    logic hw_opt, next_hw_opt;
    logic halt_opt, next_halt_opt;
    logic eff_active, tick, sw_rst, expiry, halt_rst, trigger;
    logic [6:0] step_inc;
    logic [14:0] period_next;
    logic [14:0] short_len;
    logic [31:0] status_word;

    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;

    // Write address and data join in either order
    always_comb begin
        wr_addr = aw_held ? aw_addr : awaddr;
        wr_data = w_held ? w_data : wdata;
        wr_strb = w_held ? w_strb : wstrb;
        wr_go = (aw_held || awvalid) && (w_held || wvalid) && !bvalid;
        ctrl_wr = wr_go && wr_strb[0]
                  && decode(wr_addr) == wrw_pkg::SEL_CTRL;
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_go) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (decode(wr_addr) == wrw_pkg::SEL_NONE)
                         ? wrw_pkg::RESP_SLVERR : wrw_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                next_aw_held = 1'b1;
                next_aw_addr = awaddr;
            end
            if (wvalid && wready) begin
                next_w_held = 1'b1;
                next_w_data = wdata;
                next_w_strb = wstrb;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    // Read channel, one cycle answer
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[wrw_pkg::ST_ACTIVE_BIT] = eff_active;
        status_word[wrw_pkg::ST_BUSY_BIT] = wdg_reset_req;
        status_word[wrw_pkg::ST_HW_BIT] = hw_opt;
        status_word[wrw_pkg::ST_HALT_BIT] = halt_opt;
        status_word[wrw_pkg::ST_TB_LSB +: 2] = timebase_select;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = wrw_pkg::RESP_OKAY;
            unique case (decode(araddr))
                wrw_pkg::SEL_CTRL: next_rdata = {24'h0, act, count};
                wrw_pkg::SEL_STATUS: next_rdata = status_word;
                wrw_pkg::SEL_NONE: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = wrw_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // Watchdog core: prescaler, count, activation and reset pulse
    always_comb begin
        eff_active = act || hw_opt;
        tick = (presc == 15'h0001);
        step_inc = (step_idx == wrw_pkg::STEP_MAX) ? step_idx
                   : step_idx + 7'h01;
        short_len = 15'((wrw_pkg::SHORT_BASE
                         + int'(wrw_pkg::tb_lsb(timebase_select)))
                        * wrw_pkg::SHORT_MULT);
        // Steps past a correction boundary are shortened
        if (step_inc <= {1'b0, cnt_wr}
            && short_step(step_inc, wrw_pkg::tb_msb(timebase_select))) begin
            period_next = short_len;
        end else begin
            period_next = wrw_pkg::PRESC_PERIOD;
        end
        // Prescaler is never reloaded by a write
        next_presc = tick ? period_next : presc - 15'h0001;
        next_act = act;
        next_count = count;
        next_step_idx = step_idx;
        next_cnt_wr = cnt_wr;
        if (ctrl_wr) begin
            next_act = act || wr_data[wrw_pkg::CTRL_ACT_BIT];
            next_count = wr_data[6:0];
            next_cnt_wr = wr_data[5:0];
            next_step_idx = 7'h00;
        end else if (tick) begin
            next_count = count - 7'h01;
            next_step_idx = step_inc;
        end
        sw_rst = ctrl_wr && !wr_data[wrw_pkg::CTRL_TOP_BIT]
                 && (eff_active || wr_data[wrw_pkg::CTRL_ACT_BIT]);
        expiry = tick && !ctrl_wr && eff_active
                 && count == wrw_pkg::EXPIRY_COUNT;
        halt_rst = halt_exec && eff_active && halt_opt;
        trigger = sw_rst || expiry || halt_rst;
        // Pulse is not retriggered while running
        if (pulse_cnt != 4'h0) begin
            next_pulse_cnt = pulse_cnt - 4'h1;
        end else if (trigger) begin
            next_pulse_cnt = 4'(wrw_pkg::RST_PULSE_CYCLES);
        end else begin
            next_pulse_cnt = 4'h0;
        end
        next_req = (next_pulse_cnt != 4'h0);
        // Option bits sampled once after reset release
        next_opt_taken = 1'b1;
        next_hw_opt = opt_taken ? hw_opt : hw_watchdog_option;
        next_halt_opt = opt_taken ? halt_opt : halt_reset_option;
    end

    assign halt_enter = halt_exec && !halt_rst;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            act <= wrw_pkg::CTRL_RESET[wrw_pkg::CTRL_ACT_BIT];
            count <= wrw_pkg::CTRL_RESET[6:0];
            presc <= wrw_pkg::PRESC_PERIOD;
            step_idx <= 7'h00;
            cnt_wr <= wrw_pkg::CTRL_RESET[5:0];
            pulse_cnt <= 4'h0;
            wdg_reset_req <= 1'b0;
            opt_taken <= 1'b0;
            hw_opt <= 1'b0;
            halt_opt <= 1'b0;
        end else begin
            act <= next_act;
            count <= next_count;
            presc <= next_presc;
            step_idx <= next_step_idx;
            cnt_wr <= next_cnt_wr;
            pulse_cnt <= next_pulse_cnt;
            wdg_reset_req <= next_req;
            opt_taken <= next_opt_taken;
            hw_opt <= next_hw_opt;
            halt_opt <= next_halt_opt;
        end
    end

    // Checks
    sequence s_pulse_ten;
        wdg_reset_req [*8] ##1 wdg_reset_req [*2] ##1 !wdg_reset_req;
    endsequence

    a_tick_decrements: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        tick && !ctrl_wr |=> count == $past(count) - 7'h01)
        else $error("count did not drop on prescaler tick");
    a_expiry_reset: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        eff_active && tick && !ctrl_wr && count == wrw_pkg::EXPIRY_COUNT
        && !wdg_reset_req |=> wdg_reset_req
        && count == wrw_pkg::EXPIRY_COUNT - 7'h01)
        else $error("expiry did not start reset");
    a_runs_inactive: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !eff_active && tick && !ctrl_wr && !halt_exec
        && !wdg_reset_req |=> !wdg_reset_req && count != $past(count))
        else $error("inactive count stalled or reset");
    a_act_sticky: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        act |=> act)
        else $error("activation bit cleared");
    a_sw_reset: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        ctrl_wr && wr_data[7] && !wr_data[6] && !wdg_reset_req
        |=> wdg_reset_req)
        else $error("software reset missing");
    a_halt_reset: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        halt_exec && eff_active && halt_opt
        |-> !halt_enter ##1 (wdg_reset_req || $past(wdg_reset_req)))
        else $error("halt while active did not reset");
    a_presc_kept: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        ctrl_wr && !tick |=> presc == $past(presc) - 15'h0001)
        else $error("write disturbed the prescaler");
    a_hw_option: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        hw_opt && ctrl_wr && !wr_data[wrw_pkg::CTRL_TOP_BIT]
        && !wdg_reset_req |=> wdg_reset_req)
        else $error("hardware option top bit clear did not reset");
    a_pulse_length: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        $rose(wdg_reset_req) |-> s_pulse_ten)
        else $error("reset pulse length wrong");
    a_step_period: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        tick |=> presc == wrw_pkg::PRESC_PERIOD
        || presc == $past(short_len))
        else $error("prescaler reload value wrong");
endmodule : wrw_watchdog

// ---- sim/wrw_testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [1:0] timebase_select = 2'h2;
    logic hw_watchdog_option = 1'h0, halt_reset_option = 1'h1;
    logic halt_exec = 1'h0;
    logic halt_enter, wdg_reset_req;
    int n_fail = 0, comparisons = 0, cycles = 0;
    int plen = 0, last_len = 0, npulse = 0, rise_cyc = 0;
    logic [31:0] d;
    logic [1:0] r;

    wrw_watchdog u_wrw_watchdog (.ref_clk(ref_clk), .resetn(resetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timebase_select(timebase_select),
        .hw_watchdog_option(hw_watchdog_option),
        .halt_reset_option(halt_reset_option), .halt_exec(halt_exec),
        .halt_enter(halt_enter), .wdg_reset_req(wdg_reset_req));

    // Clock generation
    always #25 ref_clk = ~ref_clk;

    // Cycle count, reset pulse measurement and hang limit
    always @(posedge ref_clk) begin
        cycles++;
        if (wdg_reset_req === 1'h1) begin
            if (plen == 0) rise_cyc = cycles;
            plen++;
        end else if (plen != 0) begin
            last_len = plen;
            npulse++;
            plen = 0;
        end
        if (cycles == 90000) begin
            n_fail++;
            $display("unexpected at %0t: run too long", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task automatic check_word(input logic [31:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h", $time, m, got);
        end
    endtask : check_word

    task automatic check_resp(input logic [1:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s resp %h", $time, m, got);
        end
    endtask : check_resp

    task automatic check_count(input int got, lo, hi, input string m);
        comparisons++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("unexpected at %0t: %s count %0d", $time, m, got);
        end
    endtask : check_count

    // AXI4-Lite write, address and data offered together
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                             output logic [1:0] resp);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (awvalid && awready) begin
                aw_done = 1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready) begin
                w_done = 1;
                wvalid <= 1'h0;
            end
        end
        while (bvalid !== 1'h1) @(posedge ref_clk);
        resp = bresp;
        bready <= 1'h0;
    endtask : axi_write

    // AXI4-Lite read
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                            output logic [1:0] resp);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge ref_clk); while (!(arready === 1'h1));
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge ref_clk);
        v = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask : axi_read

    task automatic do_reset(input logic hw);
        @(posedge ref_clk);
        resetn <= 1'h0;
        hw_watchdog_option <= hw;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'h1;
    endtask : do_reset

    // Waits until a complete reset pulse has been seen or limit cycles have passed
    task automatic wait_pulse(input int limit);
        int start;
        start = npulse;
        repeat (limit) begin
            @(posedge ref_clk);
            if (npulse != start) break;
        end
    endtask : wait_pulse

    // One-cycle halt, halt_enter checked mid-cycle
    task automatic do_halt(input logic exp_enter);
        @(posedge ref_clk);
        halt_exec <= 1'h1;
        @(negedge ref_clk);
        check_word({31'h0, halt_enter}, {31'h0, exp_enter}, "halt_enter");
        @(posedge ref_clk);
        halt_exec <= 1'h0;
    endtask : do_halt

    function automatic logic [31:0] st_exp(input logic a, h);
        st_exp = 32'h0;
        st_exp[wrw_pkg::ST_ACTIVE_BIT] = a;
        st_exp[wrw_pkg::ST_HW_BIT] = h;
        st_exp[wrw_pkg::ST_HALT_BIT] = halt_reset_option;
        st_exp[wrw_pkg::ST_TB_LSB +: 2] = timebase_select;
    endfunction : st_exp

    // Fresh reset, control write, then time to the reset pulse
    task automatic expiry(input logic [7:0] v, input logic [1:0] tb,
                          input int lo, hi);
        int t0;
        do_reset(1'h0);
        timebase_select <= tb;
        axi_write(wrw_pkg::CTRL_OFFSET, {24'h0, v}, r);
        t0 = cycles;
        wait_pulse(hi + 20);
        check_count(rise_cyc - t0, lo, hi, "expiry time");
        check_count(last_len, 10, 10, "pulse length");
    endtask : expiry

    initial begin
        do_reset(1'h0);
        axi_read(wrw_pkg::CTRL_OFFSET, d, r);
        check_word(d, 32'h7f, "ctrl reset");
        axi_read(wrw_pkg::STATUS_OFFSET, d, r);
        check_word(d, st_exp(1'h0, 1'h0), "status reset");
        axi_read(8'h08, d, r);
        check_resp(r, wrw_pkg::RESP_SLVERR, "unmapped read");
        axi_write(wrw_pkg::STATUS_OFFSET, 32'hff, r);
        check_resp(r, wrw_pkg::RESP_OKAY, "status write");
        $display("test registers done");
        axi_write(wrw_pkg::CTRL_OFFSET, 32'h40, r);
        do_halt(1'h1);
        wait_pulse(16400);
        axi_read(wrw_pkg::CTRL_OFFSET, d, r);
        check_word(d, 32'h3f, "count while inactive");
        check_count(npulse, 0, 0, "no pulse inactive");
        $display("test free running done");
        axi_write(wrw_pkg::CTRL_OFFSET, 32'hff, r);
        axi_write(wrw_pkg::CTRL_OFFSET, 32'h7f, r);
        axi_read(wrw_pkg::CTRL_OFFSET, d, r);
        check_word(d & 32'h80, 32'h80, "sticky activate");
        axi_read(wrw_pkg::STATUS_OFFSET, d, r);
        check_word(d, st_exp(1'h1, 1'h0), "status active");
        $display("test sticky done");
        axi_write(wrw_pkg::CTRL_OFFSET, 32'h80, r);
        wait_pulse(40);
        check_count(npulse, 1, 1, "software reset");
        check_count(last_len, 10, 10, "pulse length");
        do_halt(1'h0);
        wait_pulse(40);
        check_count(npulse, 2, 2, "halt reset");
        do_reset(1'h0);
        axi_read(wrw_pkg::CTRL_OFFSET, d, r);
        check_word(d, 32'h7f, "ctrl after reset");
        $display("test forced resets done");
        expiry(8'hc0, 2'h2, 16000, 16400);
        $display("test expiry done");
        expiry(8'hc2, 2'h0, 44096, 48512);
        $display("test two steps done");
        timebase_select <= 2'h1;
        halt_reset_option <= 1'h0;
        do_reset(1'h1);
        axi_read(wrw_pkg::STATUS_OFFSET, d, r);
        check_word(d, st_exp(1'h1, 1'h1), "hw option status");
        do_halt(1'h1);
        axi_write(wrw_pkg::CTRL_OFFSET, 32'h3f, r);
        wait_pulse(40);
        check_count(npulse, 5, 5, "hw option reset");
        $display("test hardware option done");
        final_report();
    end
endmodule : testbench
